// File: l2_cache_request_control.sv
// request control and tag store of the unified second-level cache
// Behaviour
// (RULE1) tag store of two ways, 4096 entries each, over external SRAM
// (RULE2) a tag covers two sectors, or four at one megabyte
// (RULE3) each sector keeps valid and modified bits: invalid/exclusive/modified
// (RULE4) SRAM address uses bits 16:0, 15:0 or 14:0 by size
// (RULE5) cacheable requests look up tags; hits served, misses go to bus
// (RULE6) fills allocate valid clean; modified victim sectors cast out first
// (RULE7) accept one fetch, one load and two stores outstanding
// (RULE8) snoops first, then data in arrival order, fetches last
// (RULE9) hits served under a miss; a second read miss waits
// (RULE10) read hits return data and update the LRU bit
// (RULE11) copy-back burst writes go only to cache, sector marked modified
// (RULE12) write-through burst writes stay clean and go to the bus
// (RULE13) every SRAM beat gets its own address
// (RULE14) single-beat read miss changes nothing and goes to the bus
// (RULE15) copy-back single store hit updates; a miss goes to the bus
// (RULE16) write-through single store updates on hit, always goes to bus
// (RULE17) cache-inhibited requests bypass the cache, no tag change
// (RULE18) store-conditional miss or lost reservation goes to the bus
// (RULE19) store-conditional hit clean under write-through: bus and invalidate
// (RULE20) flush with first-level push goes to bus, invalidates a hit
// (RULE21) flush without any push is broadcast only if broadcast enabled
// (RULE22) data invalidate acts on a hit, broadcast if enabled
// (RULE23) instruction invalidate never acts on this cache
// (RULE24) global zero broadcast on miss only; barriers go to the bus
// (RULE25) enable bit starts operation at the next request taken
// (RULE26) snoop hit on modified sector pushes it and downgrades state
`timescale 1ns/10ps
`include "l2c_params.svh"
module l2_cache_request_control
  import l2c_pkg::*;
(
  input wire logic sys_clk, // core clock
  input wire logic rst, // async reset
  input wire logic hsel, // ahb select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size, word only
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response
  output logic [31:0] hrdata, // ahb read data
  input wire logic ireq_valid, // fetch request
  output logic ireq_ready, // fetch slot free
  input wire req_type ireq, // fetch request body
  input wire logic dreq_valid, // data request
  output logic dreq_ready, // data queue can take it
  input wire req_type dreq, // data request body
  output logic rsp_valid, // request finished
  output logic rsp_to_data, // finished request was data side
  output logic rsp_hit, // finished request hit
  input wire logic snoop_valid, // bus snoop
  input wire logic [31:0] snoop_addr, // snoop address
  input wire logic snoop_excl, // snoop wants invalidation
  output logic snoop_ready, // snoop taken
  output logic snoop_hit_mod, // last snoop hit modified
  output logic bus_valid, // bus request
  input wire logic bus_ready, // bus took request
  output bus_req_type bus_req, // bus request body
  input wire logic bus_fill_done, // bus read finished
  output logic [16:0] sram_addr, // sram beat address
  output logic sram_en, // sram access
  output logic sram_we // sram write
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [31:0] ctrl_r, hcfg_r, hrdata_r, wr_addr_r;
  logic wr_pend_r, en, ctrl_wt, abe;
  logic [1:0] sz;
  logic [14:0] tag_r [0:1][0:4095];
  logic [3:0] vld_r [0:1][0:4095];
  logic [3:0] mod_r [0:1][0:4095];
  logic lru_r [0:4095];
  req_type dq_r [0:2];
  req_type iq_r, r;
  logic [1:0] dq_cnt_r, n_ld, n_st;
  logic iq_v_r, push_d, pop_d, blk_d, blk_i, go, wt;
  logic sel_snp, sel_fill, sel_d, sel_i;
  logic miss_pend_r, fill_pend_r, miss_alloc_r, miss_side_r;
  logic [31:0] miss_addr_r, sel_addr, jaddr_r;
  look_type lk, lk_d, lk_i;
  job_type j, jb_r;
  state_type st_r;
  logic [2:0] beat_r;
  logic vway, cast_way_r, jl1_r, jdata_r, jhit_r, done, rsp_r;
  logic [3:0] bitm, c_mask, cast_mask_r;
  logic [14:0] cast_tag_r;
  logic [11:0] cast_idx_r;
  logic [1:0] cast_sect;
  logic [16:0] jbase_r;

  function automatic logic is_read(input op_type o);
    return o == OP_RD_BURST || o == OP_RD_SINGLE;
  endfunction

  function automatic logic [11:0] set_index(input logic [31:0] a);
    if (sz == `SIZE_1M) return a[18:7];
    else if (sz == `SIZE_512K) return a[17:6];
    else return {1'b0, a[16:6]};
  endfunction

  function automatic logic [16:0] sram_base(input logic w,
    input logic [11:0] i, input logic [1:0] s);
    if (sz == `SIZE_1M) return {w, i, s, 2'b00}; // [RULE4]
    else if (sz == `SIZE_512K) return {1'b0, w, i, s[0], 2'b00};
    else return {2'b00, w, i[10:0], s[0], 2'b00};
  endfunction

  function automatic logic [31:0] line_addr(input logic [14:0] t,
    input logic [11:0] i, input logic [1:0] s);
    if (sz == `SIZE_1M) return {t[14:2], i, s, 5'h00};
    else return {t, i[10:0], s[0], 5'h00};
  endfunction

  // a tag matches only with at least one valid sector behind it
  function automatic look_type lookup(input logic [31:0] a);
    look_type l;
    logic [3:0] b;
    l = '0;
    l.idx = set_index(a);
    l.sect = (sz == `SIZE_1M) ? a[6:5] : {1'b0, a[5]}; // [RULE2]
    b = 4'h1 << l.sect;
    for (int w = 0; w < 2; w++)
      if (vld_r[w][l.idx] != 4'h0 && tag_r[w][l.idx] == a[31:17])
      begin
        l.tag_hit = 1'b1;
        l.way = 1'(w);
        l.hit = (vld_r[w][l.idx] & b) != 4'h0; // [RULE3]
        l.modified = (mod_r[w][l.idx] & b) != 4'h0;
      end
    return l;
  endfunction

  assign en = ctrl_r[`CTRL_EN_BIT];
  assign ctrl_wt = ctrl_r[`CTRL_WT_BIT];
  assign sz = ctrl_r[`CTRL_SIZE_LO +: 2];
  assign abe = hcfg_r[`HCFG_ABE_BIT];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h0;
      hrdata_r <= 32'h0;
    end
    else
    begin
      wr_pend_r <= hsel && htrans[1] && hready && hwrite;
      if (hsel && htrans[1] && hready)
        wr_addr_r <= haddr;
      if (!(hsel && htrans[1] && hready && !hwrite))
        hrdata_r <= 32'h0;
      else if (haddr == `OFS_CTRL)
        hrdata_r <= ctrl_r;
      else if (haddr == `OFS_HCFG)
        hrdata_r <= hcfg_r;
      else if (haddr == `OFS_STAT)
        hrdata_r <= {27'h0, fill_pend_r, miss_pend_r, st_r};
      else
        hrdata_r <= 32'h0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= `CTRL_RST;
      hcfg_r <= `HCFG_RST;
    end
    else if (wr_pend_r && wr_addr_r == `OFS_CTRL)
      ctrl_r <= hwdata & `CTRL_MASK; // [RULE25]
    else if (wr_pend_r && wr_addr_r == `OFS_HCFG)
      hcfg_r <= hwdata & `HCFG_MASK;
  end

  // stores count cache operations too; a pop in the same cycle is ignored
  always_comb
  begin
    n_ld = 2'h0;
    n_st = 2'h0;
    for (int i = 0; i < 3; i++)
      if (2'(i) < dq_cnt_r)
      begin
        if (is_read(dq_r[i].op)) n_ld = n_ld + 2'h1;
        else n_st = n_st + 2'h1;
      end
  end

  assign dreq_ready = is_read(dreq.op) ? // [RULE7]
    n_ld == 2'h0 : n_st < 2'h2;
  assign ireq_ready = !iq_v_r; // [RULE7]
  assign push_d = dreq_valid && dreq_ready;
  assign pop_d = go && sel_d;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dq_cnt_r <= 2'h0;
      iq_v_r <= 1'b0;
    end
    else
    begin
      if (pop_d)
      begin
        dq_r[0] <= dq_r[1];
        dq_r[1] <= dq_r[2];
      end
      if (push_d)
        dq_r[pop_d ? dq_cnt_r - 2'h1 : dq_cnt_r] <= dreq;
      dq_cnt_r <= 2'(dq_cnt_r + {1'b0, push_d} - {1'b0, pop_d});
      if (ireq_valid && ireq_ready)
        iq_r <= ireq;
      iq_v_r <= (iq_v_r && !(go && sel_i)) || (ireq_valid && ireq_ready);
    end
  end

  // always_comb so that tag and size changes behind the call are seen
  always_comb lk_d = lookup(dq_r[0].addr);
  always_comb lk_i = lookup(iq_r.addr);
  // a read that would miss waits while an earlier miss is on the bus
  assign blk_d = is_read(dq_r[0].op) && miss_pend_r &&
    !(en && !dq_r[0].inhibit && lk_d.hit); // [RULE9]
  assign blk_i = is_read(iq_r.op) && miss_pend_r &&
    !(en && !iq_r.inhibit && lk_i.hit);
  assign go = st_r == ST_IDLE &&
    (snoop_valid || fill_pend_r || dq_cnt_r != 2'h0 || iq_v_r);
  assign sel_snp = snoop_valid; // [RULE8]
  assign sel_fill = !snoop_valid && fill_pend_r;
  assign sel_d = !snoop_valid && !fill_pend_r && dq_cnt_r != 2'h0 && !blk_d;
  assign sel_i = !snoop_valid && !fill_pend_r && !sel_d && iq_v_r && !blk_i;
  assign snoop_ready = go && sel_snp;
  assign r = sel_d ? dq_r[0] : iq_r;
  assign sel_addr = sel_snp ? snoop_addr : sel_fill ? miss_addr_r : r.addr;
  always_comb lk = lookup(sel_addr); // [RULE5]
  assign wt = ctrl_wt || r.page_wt;
  assign bitm = 4'h1 << lk.sect;

  always_comb
  begin
    j = '0;
    j.kind = BUS_ADDR_ONLY;
    if (sel_fill)
    begin
      j.alloc = miss_alloc_r; // [RULE6]
      j.we = 1'b1;
      j.beats = miss_alloc_r ? `SECT_BEATS : 3'h0;
    end
    else if (sel_snp)
    begin
      if (en && lk.hit)
      begin
        j.push = lk.modified; // [RULE26]
        j.inval = snoop_excl;
        j.clrmod = !snoop_excl;
      end
    end
    else if (!en || r.inhibit) // [RULE17] [RULE25]
    begin
      j.bus = !(r.op == OP_IINVAL || (r.op == OP_DZERO && !r.global));
      j.miss = is_read(r.op);
      if (is_read(r.op)) j.kind = BUS_READ;
      else if (r.op inside {OP_WR_BURST, OP_WR_SINGLE, OP_STWCX})
        j.kind = BUS_WRITE;
      j.burst = r.op == OP_RD_BURST || r.op == OP_WR_BURST;
    end
    else
      case (r.op)
        OP_RD_BURST, OP_RD_SINGLE:
          if (lk.hit)
          begin
            j.beats = (r.op == OP_RD_BURST) ? `SECT_BEATS : 3'h1;
            j.lru = 1'b1; // [RULE10]
          end
          else
          begin
            j.bus = 1'b1; // [RULE14]
            j.kind = BUS_READ;
            j.burst = r.op == OP_RD_BURST;
            j.miss = 1'b1;
          end
        OP_WR_BURST:
        begin
          j.beats = `SECT_BEATS;
          j.we = 1'b1;
          j.burst = 1'b1;
          j.kind = BUS_WRITE;
          j.bus = wt; // [RULE12]
          j.alloc = !lk.hit;
          j.amod = !wt;
          j.setmod = lk.hit && !wt; // [RULE11]
          j.clrmod = lk.hit && wt;
        end
        OP_WR_SINGLE:
        begin
          j.kind = BUS_WRITE;
          j.bus = wt || !lk.hit; // [RULE15] [RULE16]
          j.we = lk.hit;
          j.beats = lk.hit ? 3'h1 : 3'h0;
          j.setmod = lk.hit && !wt;
        end
        OP_STWCX:
        begin
          j.kind = BUS_WRITE;
          if (!lk.hit || !r.rsv_active)
            j.bus = 1'b1; // [RULE18]
          else if (!lk.modified && (r.l1_wt || ctrl_wt))
          begin
            j.bus = 1'b1; // [RULE19]
            j.inval = 1'b1;
          end
          else
          begin
            j.beats = 3'h1;
            j.we = 1'b1;
            j.setmod = 1'b1;
          end
        end
        OP_FLUSH:
          if (r.l1_push)
          begin
            j.bus = 1'b1; // [RULE20]
            j.kind = BUS_WRITE;
            j.burst = 1'b1;
            j.inval = lk.hit;
          end
          else
          begin
            j.push = lk.hit && lk.modified;
            j.inval = lk.hit;
            j.bus = !(lk.hit && lk.modified) && abe; // [RULE21]
          end
        OP_DINVAL:
        begin
          j.inval = lk.hit; // [RULE22]
          j.bus = abe;
        end
        OP_DZERO: j.bus = r.global && !lk.hit; // [RULE24]
        OP_BARRIER: j.bus = 1'b1;
        default: j.bus = 1'b0; // [RULE23]
      endcase
  end

  assign vway = lk.tag_hit ? lk.way : lru_r[lk.idx];
  assign c_mask = j.push ? bitm : (j.alloc && !lk.tag_hit) ?
    vld_r[vway][lk.idx] & mod_r[vway][lk.idx] : 4'h0; // [RULE6] [RULE12]

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < `NUM_SETS; i++)
      begin
        vld_r[0][i] <= 4'h0; // [RULE1]
        vld_r[1][i] <= 4'h0;
        mod_r[0][i] <= 4'h0;
        mod_r[1][i] <= 4'h0;
        lru_r[i] <= 1'b0;
      end
    end
    else if (go)
    begin
      if (j.lru)
        lru_r[lk.idx] <= !lk.way;
      if (j.inval)
      begin
        vld_r[lk.way][lk.idx] <= vld_r[lk.way][lk.idx] & ~bitm;
        mod_r[lk.way][lk.idx] <= mod_r[lk.way][lk.idx] & ~bitm;
      end
      if (j.setmod)
        mod_r[lk.way][lk.idx] <= mod_r[lk.way][lk.idx] | bitm;
      if (j.clrmod)
        mod_r[lk.way][lk.idx] <= mod_r[lk.way][lk.idx] & ~bitm;
      if (j.alloc)
      begin
        tag_r[vway][lk.idx] <= sel_addr[31:17];
        vld_r[vway][lk.idx] <= (lk.tag_hit ? vld_r[vway][lk.idx] : 4'h0)
          | bitm;
        mod_r[vway][lk.idx] <= (lk.tag_hit ? mod_r[vway][lk.idx] & ~bitm
          : 4'h0) | (j.amod ? bitm : 4'h0);
        lru_r[lk.idx] <= !vway;
      end
    end
  end

  // fill_done never repeats before the fill is taken, so set wins here
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      miss_pend_r <= 1'b0;
      fill_pend_r <= 1'b0;
      miss_alloc_r <= 1'b0;
      miss_side_r <= 1'b0;
      miss_addr_r <= 32'h0;
      snoop_hit_mod <= 1'b0;
    end
    else
    begin
      fill_pend_r <= bus_fill_done || (fill_pend_r && !(go && sel_fill));
      if (go && j.miss)
      begin
        miss_pend_r <= 1'b1;
        miss_alloc_r <= r.op == OP_RD_BURST && en && !r.inhibit;
        miss_side_r <= sel_d;
        miss_addr_r <= r.addr;
      end
      else if (go && sel_fill)
        miss_pend_r <= 1'b0;
      if (go && sel_snp)
        snoop_hit_mod <= en && lk.hit && lk.modified;
    end
  end

  always_comb
  begin
    cast_sect = 2'h0;
    for (int i = 3; i >= 0; i--)
      if (cast_mask_r[i]) cast_sect = 2'(i);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= ST_IDLE;
      beat_r <= 3'h0;
      cast_mask_r <= 4'h0;
      jb_r <= '0;
    end
    else
      case (st_r)
        ST_IDLE:
          if (go)
          begin
            jb_r <= j;
            cast_mask_r <= c_mask;
            cast_way_r <= vway;
            cast_idx_r <= lk.idx;
            cast_tag_r <= tag_r[vway][lk.idx];
            jaddr_r <= j.burst ? {sel_addr[31:5], 5'h00} : sel_addr;
            jbase_r <= sram_base(vway, lk.idx, lk.sect) |
              (j.beats == 3'h1 ? {15'h0, sel_addr[4:3]} : 17'h0);
            beat_r <= 3'h0;
            if (c_mask != 4'h0) st_r <= ST_CAST_RD;
            else if (j.beats != 3'h0) st_r <= ST_BEATS;
            else if (j.bus) st_r <= ST_BUS;
          end
        ST_CAST_RD:
        begin
          beat_r <= 3'(beat_r + 3'h1); // [RULE13]
          if (beat_r == `SECT_BEATS - 3'h1)
          begin
            beat_r <= 3'h0;
            st_r <= ST_CAST_BUS;
          end
        end
        ST_CAST_BUS:
          if (bus_ready)
          begin
            cast_mask_r <= cast_mask_r & ~(4'h1 << cast_sect);
            if ((cast_mask_r & ~(4'h1 << cast_sect)) != 4'h0)
              st_r <= ST_CAST_RD;
            else if (jb_r.beats != 3'h0) st_r <= ST_BEATS;
            else if (jb_r.bus) st_r <= ST_BUS;
            else st_r <= ST_IDLE;
          end
        ST_BEATS:
        begin
          beat_r <= 3'(beat_r + 3'h1);
          if (beat_r == jb_r.beats - 3'h1)
            st_r <= jb_r.bus ? ST_BUS : ST_IDLE;
        end
        default:
          if (bus_ready) st_r <= ST_IDLE;
      endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      jl1_r <= 1'b0;
      jdata_r <= 1'b0;
      jhit_r <= 1'b0;
      rsp_r <= 1'b0;
      rsp_to_data <= 1'b0;
      rsp_hit <= 1'b0;
    end
    else
    begin
      if (go)
      begin
        jl1_r <= sel_fill || ((sel_d || sel_i) && !j.miss);
        jdata_r <= sel_fill ? miss_side_r : sel_d;
        jhit_r <= lk.hit && !sel_fill && !r.inhibit && en;
      end
      rsp_r <= done && (go ? sel_fill || ((sel_d || sel_i) && !j.miss)
        : jl1_r);
      if (done)
      begin
        rsp_to_data <= go ? (sel_fill ? miss_side_r : sel_d) : jdata_r;
        rsp_hit <= go ? lk.hit && !sel_fill && !r.inhibit && en : jhit_r;
      end
    end
  end

  assign done = go ? (c_mask == 4'h0 && j.beats == 3'h0 && !j.bus) :
    (st_r == ST_BUS && bus_ready) || (st_r == ST_BEATS &&
    beat_r == jb_r.beats - 3'h1 && !jb_r.bus) || (st_r == ST_CAST_BUS &&
    bus_ready && (cast_mask_r & ~(4'h1 << cast_sect)) == 4'h0 &&
    jb_r.beats == 3'h0 && !jb_r.bus);
  assign rsp_valid = rsp_r;
  assign bus_valid = st_r == ST_CAST_BUS || st_r == ST_BUS;
  always_comb bus_req = (st_r == ST_CAST_BUS) ? {BUS_WRITE, 1'b1,
    line_addr(cast_tag_r, cast_idx_r, cast_sect)} :
    {jb_r.kind, jb_r.burst, jaddr_r};
  assign sram_en = st_r == ST_CAST_RD || st_r == ST_BEATS;
  assign sram_we = st_r == ST_BEATS && jb_r.we;
  always_comb sram_addr = ((st_r == ST_CAST_RD) ?
    sram_base(cast_way_r, cast_idx_r, cast_sect) : jbase_r) |
    {14'h0, beat_r}; // [RULE13]

  sequence seq_cast_read;
    (sram_en && !sram_we)[*4];
  endsequence
  chk_cast_first: assert property ( // [RULE6]
    go && j.alloc && c_mask != 4'h0 |=>
    seq_cast_read ##1 bus_valid) else $error("castout not first");
  chk_snoop_first: assert property (go && snoop_valid |-> // [RULE8]
    snoop_ready && !pop_d) else $error("snoop not first");
  chk_miss_wait: assert property (miss_pend_r && dq_cnt_r != 2'h0 && // [RULE9]
    is_read(dq_r[0].op) && !lk_d.hit |-> !pop_d)
    else $error("second miss taken");
  chk_beat_step: assert property ( // [RULE13]
    st_r == ST_BEATS && beat_r != 3'h0 |->
    sram_addr == $past(sram_addr) + 17'h1) else $error("beat address");
  chk_sram_bits: assert property (sram_en && sz != `SIZE_1M |-> // [RULE4]
    !sram_addr[16] && (sz == `SIZE_512K || !sram_addr[15]))
    else $error("sram address width");
  chk_inhibit_pass: assert property (go && (sel_d || sel_i) && // [RULE17]
    r.inhibit |=> !sram_en[*2]) else $error("inhibited used cache");
  chk_off_idle: assert property (go && !en && !sel_fill |=> // [RULE25]
    !sram_en) else $error("disabled cache acted");
  chk_inval_quiet: assert property (go && sel_d && en && !r.inhibit && // [RULE22]
    r.op == OP_DINVAL && !abe |=> !bus_valid) else $error("dinval sent");
  chk_iinval_none: assert property (go && (sel_d || sel_i) && // [RULE23]
    r.op == OP_IINVAL |=> !bus_valid && !sram_en ##1 st_r == ST_IDLE)
    else $error("icache invalidate reached cache");
  chk_lru_hit: assert property (go && (sel_d || sel_i) && en && // [RULE10]
    !r.inhibit && is_read(r.op) && lk.hit |=>
    lru_r[$past(lk.idx)] != $past(lk.way)) else $error("lru not updated");
  chk_wt_store: assert property (go && sel_d && en && !r.inhibit && // [RULE16]
    r.op == OP_WR_SINGLE && wt |-> ##[1:4] bus_valid)
    else $error("write-through store not on bus");
  chk_load_limit: assert property (dreq_valid && dreq_ready && // [RULE7]
    is_read(dreq.op) |-> n_ld == 2'h0) else $error("two loads queued");
endmodule

// File: l2c_params.svh
// register offsets, field positions, reset values and counts
`ifndef L2C_PARAMS_SVH
`define L2C_PARAMS_SVH
`define OFS_CTRL 32'h0000_0000
`define OFS_HCFG 32'h0000_0004
`define OFS_STAT 32'h0000_0008
`define CTRL_EN_BIT 0
`define CTRL_WT_BIT 1
`define CTRL_SIZE_LO 2
`define CTRL_MASK 32'h0000_000f
`define HCFG_ABE_BIT 0
`define HCFG_MASK 32'h0000_0001
`define CTRL_RST 32'h0000_0000
`define HCFG_RST 32'h0000_0000
`define NUM_SETS 4096
`define SECT_BEATS 3'h4
`define SIZE_1M 2'h3
`define SIZE_512K 2'h2
`endif

// File: l2c_pkg.sv
// types shared by the second-level cache request control
package l2c_pkg;
  typedef enum logic [3:0] {OP_RD_BURST = 4'h0, OP_RD_SINGLE = 4'h1,
    OP_WR_BURST = 4'h2, OP_WR_SINGLE = 4'h3, OP_STWCX = 4'h4,
    OP_FLUSH = 4'h5, OP_DINVAL = 4'h6, OP_DZERO = 4'h7,
    OP_BARRIER = 4'h8, OP_IINVAL = 4'h9} op_type;
  typedef struct packed {
    op_type op;
    logic [31:0] addr;
    logic inhibit;
    logic page_wt;
    logic global;
    logic l1_wt;
    logic l1_push;
    logic rsv_active;
    logic l1_hit;
  } req_type;
  typedef enum logic [1:0] {BUS_READ = 2'h0, BUS_WRITE = 2'h1,
    BUS_ADDR_ONLY = 2'h2} bus_kind_type;
  typedef struct packed {
    bus_kind_type kind;
    logic burst;
    logic [31:0] addr;
  } bus_req_type;
  typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_CAST_RD = 3'b001,
    ST_CAST_BUS = 3'b010, ST_BEATS = 3'b011, ST_BUS = 3'b100} state_type;
  typedef struct packed {
    logic hit;
    logic tag_hit;
    logic way;
    logic modified;
    logic [11:0] idx;
    logic [1:0] sect;
  } look_type;
  typedef struct packed {
    logic bus;
    bus_kind_type kind;
    logic burst;
    logic [2:0] beats;
    logic we;
    logic push;
    logic inval;
    logic setmod;
    logic clrmod;
    logic lru;
    logic miss;
    logic alloc;
    logic amod;
  } job_type;
endpackage

// File: bus_model.sv
// system bus interface model that takes requests and returns fills
`timescale 1ns/10ps
module bus_model
  import l2c_pkg::*;
(
  input wire logic sys_clk, // core clock
  input wire logic rst, // async reset
  input wire logic bus_valid, // request from cache
  input wire bus_req_type bus_req, // request body
  output logic bus_ready, // request taken
  output logic bus_fill_done // read data delivered
);
  logic [1:0] wait_r;
  // odd and even phases give prompt and slow answers in turn
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wait_r <= 2'h0;
      bus_ready <= 1'b0;
      bus_fill_done <= 1'b0;
    end
    else
    begin
      wait_r <= wait_r + 2'h1;
      bus_ready <= bus_valid && !bus_ready && wait_r[0];
      bus_fill_done <= bus_valid && bus_ready && bus_req.kind == BUS_READ;
    end
  end
endmodule

// File: l2_cache_request_control_tb.sv
// self-checking bench of the second-level cache request control
`timescale 1ns/10ps
`include "l2c_params.svh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
module l2_cache_request_control_tb
  import l2c_pkg::*;
;
  logic sys_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic dreq_valid = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  req_type dreq = '0, ireq = '0;
  wire logic hready, hresp, ireq_ready, dreq_ready, rsp_valid, rsp_to_data;
  wire logic rsp_hit, snoop_ready, snoop_hit_mod, bus_valid, bus_ready;
  wire logic bus_fill_done, sram_en, sram_we;
  wire logic [31:0] hrdata;
  wire logic [16:0] sram_addr;
  wire bus_req_type bus_req;
  int failures = 0, compares = 0, cycles = 0, bus_n = 0, sram_n = 0, nb, ns;
  logic h;
  bus_kind_type k, bus_k;
  localparam logic [31:0] A = 32'h0000_1000, B = 32'h0000_2040;
  l2_cache_request_control i_dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .ireq_valid(1'b0), .ireq_ready(ireq_ready),
    .ireq(ireq), .dreq_valid(dreq_valid), .dreq_ready(dreq_ready),
    .dreq(dreq), .rsp_valid(rsp_valid), .rsp_to_data(rsp_to_data),
    .rsp_hit(rsp_hit), .snoop_valid(1'b0), .snoop_addr(32'h0),
    .snoop_excl(1'b0), .snoop_ready(snoop_ready),
    .snoop_hit_mod(snoop_hit_mod), .bus_valid(bus_valid),
    .bus_ready(bus_ready), .bus_req(bus_req),
    .bus_fill_done(bus_fill_done), .sram_addr(sram_addr),
    .sram_en(sram_en), .sram_we(sram_we));
  bus_model i_bus (.sys_clk(sys_clk), .rst(rst), .bus_valid(bus_valid),
    .bus_req(bus_req), .bus_ready(bus_ready), .bus_fill_done(bus_fill_done));
  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (bus_valid && bus_ready)
    begin
      bus_n++;
      bus_k = bus_req.kind;
    end
    if (sram_en)
      sram_n++;
    // generous ceiling: the whole sequence needs well under a thousand
    if (cycles == 20000)
    begin
      failures++;
      results();
    end
  end
  task automatic results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // called right after a rising edge; returns at the edge closing the data
  task automatic ahb(input logic wr, input logic [31:0] a,
    input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    // read data is taken at the edge that closes the data phase
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic req(input op_type op, input logic [31:0] a, input logic inh);
    req_type r;
    int b0, s0;
    r = '0;
    r.op = op;
    r.addr = a;
    r.inhibit = inh;
    b0 = bus_n;
    s0 = sram_n;
    dreq_valid <= 1'b1;
    dreq <= r;
    do @(posedge sys_clk); while (dreq_ready !== 1'b1);
    dreq_valid <= 1'b0;
    // rsp_valid ends this wait; it has no limit of its own but the bench timeout
    do @(posedge sys_clk); while (rsp_valid !== 1'b1);
    `CHK("rsp_valid", 1'b1, rsp_valid)
    `CHK("rsp side", 1'b1, rsp_to_data)
    h = rsp_hit;
    nb = bus_n - b0;
    ns = sram_n - s0;
    k = bus_k;
  endtask
  task automatic t_regs();
    ahb(1'b0, `OFS_CTRL, 32'h0);
    `CHK("ctrl reset", `CTRL_RST, rd)
    ahb(1'b1, `OFS_CTRL, 32'hffff_ffff);
    ahb(1'b0, `OFS_CTRL, 32'h0);
    `CHK("ctrl mask", `CTRL_MASK, rd)
    ahb(1'b0, 32'h0000_000c, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    $display("t_regs done");
  endtask
  task automatic t_off();
    ahb(1'b1, `OFS_CTRL, 32'h0);
    req(OP_RD_BURST, A, 1'b0);
    `CHK("off bus", 1, nb)
    `CHK("off hit", 1'b0, h)
    $display("t_off done");
  endtask
  task automatic t_fill();
    ahb(1'b1, `OFS_CTRL, 32'h1);
    req(OP_RD_BURST, A, 1'b0);
    `CHK("miss bus", 1, nb)
    `CHK("miss kind", BUS_READ, k)
    `CHK("fill beats", 4, ns)
    req(OP_RD_BURST, A, 1'b0);
    `CHK("hit", 1'b1, h)
    `CHK("hit bus", 0, nb)
    `CHK("hit beats", 4, ns)
    $display("t_fill done");
  endtask
  task automatic t_bypass();
    req(OP_RD_SINGLE, B, 1'b0);
    `CHK("single miss bus", 1, nb)
    req(OP_RD_BURST, B, 1'b0);
    `CHK("no alloc", 1'b0, h)
    req(OP_RD_SINGLE, A, 1'b1);
    `CHK("inhibit bus", 1, nb)
    `CHK("inhibit hit", 1'b0, h)
    req(OP_RD_BURST, A, 1'b0);
    `CHK("tag kept", 1'b1, h)
    $display("t_bypass done");
  endtask
  task automatic t_ops();
    req(OP_DINVAL, B, 1'b0);
    `CHK("inval quiet", 0, nb)
    ahb(1'b1, `OFS_HCFG, 32'h1);
    req(OP_DINVAL, A, 1'b0);
    `CHK("inval bus", 1, nb)
    `CHK("inval kind", BUS_ADDR_ONLY, k)
    req(OP_RD_BURST, A, 1'b0);
    `CHK("inval gone", 1'b0, h)
    req(OP_BARRIER, A, 1'b0);
    `CHK("barrier bus", 1, nb)
    req(OP_WR_BURST, A, 1'b0);
    `CHK("copyback bus", 0, nb)
    // two more tags at this set push the modified way out as victim
    req(OP_RD_BURST, A + 32'h0002_0000, 1'b0);
    req(OP_RD_BURST, A + 32'h0004_0000, 1'b0);
    `CHK("castout bus", 2, nb)
    `CHK("castout beats", 8, ns)
    ahb(1'b1, `OFS_CTRL, 32'h3);
    req(OP_WR_BURST, A, 1'b0);
    `CHK("wt bus", 1, nb)
    `CHK("wt kind", BUS_WRITE, k)
    $display("t_ops done");
  endtask
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_off();
    t_fill();
    t_bypass();
    t_ops();
    results();
  end
endmodule
